// ---- hdl/snp_pkg.sv ----
package snp_pkg;
    // clock and time units
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam int unsigned MS_PER_MIN = 60000;
    // packing buffer
    localparam int unsigned BUF_DEPTH = 1024;
    localparam int unsigned BUF_AW = 10;
    localparam int unsigned CNT_W = 11;
    localparam logic [CNT_W-1:0] CNT_FULL = 11'h400;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    // settings
    localparam logic [7:0] NO_MARK = 8'h00;
    localparam logic [15:0] FORCE_OFF = 16'h0000;
    localparam logic [15:0] MS_SAT = 16'hffff;
    localparam logic [6:0] ALIVE_OFF = 7'h00;
    localparam logic [15:0] PORT_DEFAULT = 16'h0fa1;
    localparam logic [15:0] PORT_NONE = 16'h0000;
    localparam int unsigned N_CONN = 4;
    localparam logic [2:0] CONN_MIN = 3'h1;
    localparam logic [2:0] CONN_MAX = 3'h4;
    typedef enum {SNP_FILL, SNP_DRAIN} snp_state_t;
endpackage

// ---- hdl/snp_alive_watch.sv ----
`timescale 1ns/1ns
module snp_alive_watch
    import snp_pkg::*;
(
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // session state
    input wire logic active_i,
    input wire logic activity_i,
    input wire logic min_tick_i,
    input wire logic [6:0] limit_i,
    // expiry pulse
    output logic expire_o
);
    logic [6:0] min_q, min_d;
    logic expire_q, expire_d;

    always_comb begin
        min_d = min_q;
        // any traffic restarts the idle count
        if (!active_i || activity_i) begin
            min_d = 7'h00;
        end else if (min_tick_i && min_q != limit_i) begin
            min_d = min_q + 7'h01;
        end
        expire_d = active_i && !activity_i && limit_i != ALIVE_OFF
            && min_q == limit_i && !expire_q;
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            min_q <= 7'h00;
            expire_q <= 1'b0;
        end else begin
            min_q <= min_d;
            expire_q <= expire_d;
        end
    end

    assign expire_o = expire_q;

    alive_off_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        limit_i == ALIVE_OFF |=> !expire_q)
        else $error("session dropped with alive check disabled");
endmodule

// ---- hdl/snp_packer.sv ----
`timescale 1ns/1ns
module snp_packer
    import snp_pkg::*;
#(
    parameter int unsigned CYC_MS = CYC_PER_MS,
    parameter int unsigned MS_MIN = MS_PER_MIN
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // serial receive stream
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    output logic rx_ready_o,
    // frames toward network
    output logic frm_valid_o,
    output logic [7:0] frm_data_o,
    output logic frm_last_o,
    input wire logic frm_ready_i,
    // network data toward serial
    input wire logic net_valid_i,
    input wire logic [7:0] net_data_i,
    output logic net_ready_o,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    input wire logic tx_ready_i,
    // settings
    input wire logic [7:0] mark1_i,
    input wire logic [7:0] mark2_i,
    input wire logic [15:0] force_ms_i,
    input wire logic [15:0] local_port_i,
    input wire logic [6:0] idle_session_timeout_i,
    input wire logic [2:0] max_conn_i,
    // host sessions
    input wire logic [N_CONN-1:0] open_req_i,
    input wire logic [N_CONN-1:0] close_req_i,
    input wire logic [N_CONN-1:0] close_done_i,
    input wire logic [N_CONN-1:0] activity_i,
    input wire logic [N_CONN-1:0] port_ctrl_i,
    output logic [15:0] listen_port_o,
    output logic listening_o,
    output logic [N_CONN-1:0] conn_active_o,
    output logic [N_CONN-1:0] conn_accept_o,
    output logic [N_CONN-1:0] conn_drop_o,
    output logic [N_CONN-1:0] port_ctrl_o,
    output logic local_params_o,
    output logic suspend_o
);
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // packing path; storage is an async-read array, no reset needed
    logic [7:0] mem [BUF_DEPTH];
    snp_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d, rd_q, rd_d;
    logic prev_m1_q, prev_m1_d;
    logic [15:0] div_q, div_d, idle_q, idle_d;
    logic rx_ready_q, rx_ready_d, frm_valid_q, frm_valid_d, frm_last_q, frm_last_d;
    logic [7:0] frm_data_q, frm_data_d;
    logic acc, mark_hit, close_now, susp_d;

    assign acc = rx_valid_i && rx_ready_q;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        prev_m1_d = prev_m1_q;
        div_d = div_q;
        idle_d = idle_q;
        frm_valid_d = frm_valid_q;
        frm_data_d = frm_data_q;
        frm_last_d = frm_last_q;
        mark_hit = 1'b0;
        close_now = 1'b0;
        if (frm_ready_i) begin
            frm_valid_d = 1'b0;
        end
        unique case (state_q)
            SNP_FILL: begin
                if (acc) begin
                    cnt_d = cnt_q + 11'h001;
                    prev_m1_d = mark1_i != NO_MARK && rx_data_i == mark1_i;
                    if (mark1_i == NO_MARK && mark2_i == NO_MARK) begin
                        mark_hit = 1'b1;
                    end else if (mark2_i == NO_MARK) begin
                        mark_hit = rx_data_i == mark1_i;
                    end else begin
                        mark_hit = prev_m1_q && rx_data_i == mark2_i;
                    end
                    // marker and full on one byte still give one frame
                    close_now = mark_hit || cnt_d == CNT_FULL;
                    div_d = 16'h0000;
                    idle_d = 16'h0000;
                end else begin
                    if (div_q == 16'(CYC_MS - 1)) begin
                        div_d = 16'h0000;
                        if (idle_q != MS_SAT) begin
                            idle_d = idle_q + 16'h0001;
                        end
                    end else begin
                        div_d = div_q + 16'h0001;
                    end
                    // a gap below one character time fires on every byte
                    close_now = cnt_q != CNT_ZERO && force_ms_i != FORCE_OFF
                        && idle_q >= force_ms_i;
                end
                if (close_now) begin
                    state_d = SNP_DRAIN;
                    rd_d = CNT_ZERO;
                end
            end
            SNP_DRAIN: begin
                div_d = 16'h0000;
                idle_d = 16'h0000;
                if (!frm_valid_q || frm_ready_i) begin
                    frm_valid_d = 1'b1;
                    frm_data_d = mem[rd_q[BUF_AW-1:0]];
                    frm_last_d = rd_q == cnt_q - 11'h001;
                    rd_d = rd_q + 11'h001;
                    if (frm_last_d) begin
                        state_d = SNP_FILL;
                        cnt_d = CNT_ZERO;
                        prev_m1_d = 1'b0;
                    end
                end
            end
        endcase
        rx_ready_d = state_d == SNP_FILL && !susp_d;
    end

    always_ff @(posedge clock_i) begin
        if (acc && state_q == SNP_FILL) begin
            mem[cnt_q[BUF_AW-1:0]] <= rx_data_i;
        end
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= SNP_FILL;
            cnt_q <= CNT_ZERO;
            rd_q <= CNT_ZERO;
            prev_m1_q <= 1'b0;
            div_q <= 16'h0000;
            idle_q <= 16'h0000;
            rx_ready_q <= 1'b0;
            frm_valid_q <= 1'b0;
            frm_data_q <= 8'h00;
            frm_last_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            prev_m1_q <= prev_m1_d;
            div_q <= div_d;
            idle_q <= idle_d;
            rx_ready_q <= rx_ready_d;
            frm_valid_q <= frm_valid_d;
            frm_data_q <= frm_data_d;
            frm_last_q <= frm_last_d;
        end
    end

    // network to serial: one stage keeps arrival order; half rate is ample for a uart
    logic tx_valid_q, tx_valid_d, net_ready_q, net_ready_d;
    logic [7:0] tx_data_q, tx_data_d;

    always_comb begin
        tx_valid_d = tx_valid_q;
        tx_data_d = tx_data_q;
        if (tx_ready_i) begin
            tx_valid_d = 1'b0;
        end
        if (net_valid_i && net_ready_q) begin
            tx_valid_d = 1'b1;
            tx_data_d = net_data_i;
        end
        net_ready_d = !tx_valid_d && !susp_d;
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            tx_valid_q <= 1'b0;
            tx_data_q <= 8'h00;
            net_ready_q <= 1'b0;
        end else begin
            tx_valid_q <= tx_valid_d;
            tx_data_q <= tx_data_d;
            net_ready_q <= net_ready_d;
        end
    end

    // sessions
    logic [2:0] eff_q, eff_d;
    logic [15:0] port_q, port_d;
    logic [N_CONN-1:0] act_q, act_d, clo_q, clo_d, acpt_q, acpt_d, drop_q, ctrl_q, ctrl_d;
    logic [N_CONN-1:0] expire;
    logic listen_q, listen_d, lparm_q, lparm_d, susp_q;
    logic [15:0] fdiv_q, fdiv_d, mins_q, mins_d;
    logic tick_q, tick_d;
    logic [2:0] used;

    always_comb begin
        eff_d = max_conn_i < CONN_MIN ? CONN_MIN
            : (max_conn_i > CONN_MAX ? CONN_MAX : max_conn_i);
        port_d = local_port_i == PORT_NONE ? PORT_DEFAULT : local_port_i;
        lparm_d = eff_q != CONN_MIN;
        fdiv_d = fdiv_q + 16'h0001;
        mins_d = mins_q;
        tick_d = 1'b0;
        if (fdiv_q == 16'(CYC_MS - 1)) begin
            fdiv_d = 16'h0000;
            mins_d = mins_q + 16'h0001;
            if (mins_q == 16'(MS_MIN - 1)) begin
                mins_d = 16'h0000;
                tick_d = 1'b1;
            end
        end
        // set wins: a close request in the done cycle keeps the session closing
        clo_d = (clo_q & ~close_done_i) | (close_req_i & act_q);
        act_d = act_q & ~(close_done_i & clo_q & ~close_req_i) & ~expire;
        acpt_d = '0;
        used = 3'h0;
        for (int i = 0; i < N_CONN; i++) begin
            used = used + {2'b00, act_d[i]};
        end
        for (int i = 0; i < N_CONN; i++) begin
            if (open_req_i[i] && !act_d[i] && !clo_q[i] && used < eff_q) begin
                acpt_d[i] = 1'b1;
                act_d[i] = 1'b1;
                used = used + 3'h1;
            end
        end
        listen_d = used < eff_q;
        susp_d = (|clo_d) && lparm_d;
        ctrl_d = lparm_d ? '0 : (port_ctrl_i & act_q);
    end

    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            eff_q <= CONN_MIN;
            port_q <= PORT_DEFAULT;
            lparm_q <= 1'b0;
            fdiv_q <= 16'h0000;
            mins_q <= 16'h0000;
            tick_q <= 1'b0;
            clo_q <= '0;
            act_q <= '0;
            acpt_q <= '0;
            drop_q <= '0;
            listen_q <= 1'b0;
            susp_q <= 1'b0;
            ctrl_q <= '0;
        end else begin
            eff_q <= eff_d;
            port_q <= port_d;
            lparm_q <= lparm_d;
            fdiv_q <= fdiv_d;
            mins_q <= mins_d;
            tick_q <= tick_d;
            clo_q <= clo_d;
            act_q <= act_d;
            acpt_q <= acpt_d;
            drop_q <= expire;
            listen_q <= listen_d;
            susp_q <= susp_d;
            ctrl_q <= ctrl_d;
        end
    end

    for (genvar g = 0; g < N_CONN; g++) begin : g_watch
        snp_alive_watch u_watch (
            .clock_i(clock_i),
            .rst_n_i(rst_n),
            .active_i(act_q[g] && !clo_q[g]),
            .activity_i(activity_i[g]),
            .min_tick_i(tick_q),
            .limit_i(idle_session_timeout_i),
            .expire_o(expire[g])
        );
    end

    assign rx_ready_o = rx_ready_q;
    assign frm_valid_o = frm_valid_q;
    assign frm_data_o = frm_data_q;
    assign frm_last_o = frm_last_q;
    assign net_ready_o = net_ready_q;
    assign tx_valid_o = tx_valid_q;
    assign tx_data_o = tx_data_q;
    assign listen_port_o = port_q;
    assign listening_o = listen_q;
    assign conn_active_o = act_q;
    assign conn_accept_o = acpt_q;
    assign conn_drop_o = drop_q;
    assign port_ctrl_o = ctrl_q;
    assign local_params_o = lparm_q;
    assign suspend_o = susp_q;

    no_mark_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        acc && mark1_i == NO_MARK && mark2_i == NO_MARK |=> state_q == SNP_DRAIN
        && cnt_q != CNT_ZERO ##1 frm_valid_o)
        else $error("unmarked byte not framed at once");
    mark_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        acc && mark1_i != NO_MARK && mark2_i == NO_MARK && rx_data_i != mark1_i
        && cnt_q < CNT_FULL - 11'h001 && force_ms_i == FORCE_OFF |=> state_q == SNP_FILL)
        else $error("byte released without marker");
    pair_mark_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        acc && mark1_i != NO_MARK && mark2_i != NO_MARK && !prev_m1_q
        && cnt_q < CNT_FULL - 11'h001 && force_ms_i == FORCE_OFF |=> state_q == SNP_FILL)
        else $error("frame closed without marker pair");
    buf_full_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        acc && cnt_q == CNT_FULL - 11'h001 |=> state_q == SNP_DRAIN && cnt_q == CNT_FULL)
        else $error("full buffer not framed");
    idle_gap_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        state_q == SNP_FILL && !acc && cnt_q != CNT_ZERO && force_ms_i != FORCE_OFF
        && idle_q == force_ms_i |=> state_q == SNP_DRAIN)
        else $error("idle gap expiry missed");
    gap_off_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        state_q == SNP_FILL && !acc && force_ms_i == FORCE_OFF |=> state_q == SNP_FILL)
        else $error("frame closed with gap timer off");
    gap_restart_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        acc |=> idle_q == 16'h0000 && div_q == 16'h0000)
        else $error("gap timer not restarted");
    conn_limit_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        $countones(conn_active_o) <= int'(eff_q))
        else $error("too many sessions open");
    port_ctrl_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        |port_ctrl_o |-> !local_params_o && $past(eff_q) == CONN_MIN)
        else $error("port control passed in multi session");
    suspend_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        suspend_o |-> !rx_ready_o && !net_ready_o)
        else $error("serial traffic during close");
    fifo_hold_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("serial byte lost or reordered");
    listen_port_a: assert property (@(posedge clock_i) disable iff (!rst_n)
        listen_port_o != PORT_NONE)
        else $error("listen port zero");
endmodule

// ---- bench/snp_far_model.sv ----
`timescale 1ns/1ns
module snp_far_model (
    // clock and reset
    input wire logic clock_i,
    input wire logic reset_n_i,
    // frames from the packer
    input wire logic frm_valid_i,
    input wire logic [7:0] frm_data_i,
    input wire logic frm_last_i,
    output logic frm_ready_o,
    // bytes toward the serial device
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    logic [8:0] fq[$];
    logic [7:0] tq[$];
    logic [15:0] lfsr_q;
    // both sinks stall at random so holding of valid and data gets exercised
    always @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lfsr_q <= 16'hace1;
            frm_ready_o <= 1'b0;
            tx_ready_o <= 1'b0;
        end else begin
            lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
            frm_ready_o <= lfsr_q[0] | lfsr_q[3];
            tx_ready_o <= lfsr_q[5] | lfsr_q[7];
            if (frm_valid_i && frm_ready_o) begin
                fq.push_back({frm_last_i, frm_data_i});
            end
            if (tx_valid_i && tx_ready_o) begin
                tq.push_back(tx_data_i);
            end
        end
    end
endmodule

// ---- bench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
    import snp_pkg::*;
    logic clock_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic rx_valid_i = 1'b0;
    logic [7:0] rx_data_i = 8'h00;
    logic net_valid_i = 1'b0;
    logic [7:0] net_data_i = 8'h00;
    logic [7:0] mark1_i = 8'h00;
    logic [7:0] mark2_i = 8'h00;
    logic [15:0] force_ms_i = 16'h0000;
    logic [15:0] local_port_i = 16'h0000;
    logic [6:0] idle_session_timeout_i = 7'h00;
    logic [2:0] max_conn_i = 3'h1;
    logic [3:0] open_req_i = 4'h0;
    logic [3:0] close_req_i = 4'h0;
    logic [3:0] close_done_i = 4'h0;
    logic [3:0] activity_i = 4'h0;
    logic [3:0] port_ctrl_i = 4'h0;
    logic rx_ready_o, frm_valid_o, frm_last_o, frm_ready_i, net_ready_o, tx_valid_o, tx_ready_i;
    logic [7:0] frm_data_o, tx_data_o;
    logic [15:0] listen_port_o;
    logic listening_o, local_params_o, suspend_o;
    logic [3:0] conn_active_o, conn_accept_o, conn_drop_o, port_ctrl_o;
    integer seed = 93415;
    int error_cnt = 0;
    int tests_run = 0;
    int cnt = 0;
    int i;
    logic [7:0] prev = 8'h00;
    logic [8:0] exp_f[$];
    logic [7:0] exp_t[$];

    // short counts keep the idle gap and session timers inside a short run
    snp_packer #(.CYC_MS(4), .MS_MIN(3)) i_snp_packer (.clock_i, .reset_n_i, .rx_valid_i,
        .rx_data_i, .rx_ready_o, .frm_valid_o, .frm_data_o, .frm_last_o, .frm_ready_i,
        .net_valid_i, .net_data_i, .net_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i,
        .mark1_i, .mark2_i, .force_ms_i, .local_port_i, .idle_session_timeout_i, .max_conn_i,
        .open_req_i, .close_req_i, .close_done_i, .activity_i, .port_ctrl_i, .listen_port_o,
        .listening_o, .conn_active_o, .conn_accept_o, .conn_drop_o, .port_ctrl_o,
        .local_params_o, .suspend_o);
    snp_far_model u_far (.clock_i(clock_i), .reset_n_i(reset_n_i), .frm_valid_i(frm_valid_o),
        .frm_data_i(frm_data_o), .frm_last_i(frm_last_o), .frm_ready_o(frm_ready_i),
        .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .tx_ready_o(tx_ready_i));

    always #25 clock_i = ~clock_i;

    task automatic stop_test();
        $display("mismatches %0d, comparisons %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic hang(input string what);
        error_cnt++;
        $display("unexpected at %0t: %s never came", $time, what);
        stop_test();
    endtask

    function automatic logic closes(input logic [7:0] p, input logic [7:0] b, input int n);
        if (mark1_i == NO_MARK && mark2_i == NO_MARK) return 1'b1;
        if (n == BUF_DEPTH) return 1'b1;
        if (mark2_i == NO_MARK) return b == mark1_i;
        return mark1_i != NO_MARK && p == mark1_i && b == mark2_i;
    endfunction

    // random byte that never matches a marker, so with a marker set only count or time can close
    function automatic logic [7:0] filler();
        logic [7:0] b;
        b = 8'($random(seed));
        if (b == mark1_i || b == mark2_i) b = 8'h55;
        return b;
    endfunction

    task automatic cfg(input logic [7:0] m1, input logic [7:0] m2, input logic [15:0] ms);
        mark1_i <= m1;
        mark2_i <= m2;
        force_ms_i <= ms;
        prev = 8'h00;
        @(posedge clock_i);
    endtask

    task automatic send(input logic [7:0] b);
        int k;
        rx_valid_i <= 1'b1;
        rx_data_i <= b;
        @(negedge clock_i);
        for (k = 0; rx_ready_o !== 1'b1; k++) begin
            if (k == 5000) hang("serial accept");
            @(negedge clock_i);
        end
        @(posedge clock_i);
        cnt++;
        exp_f.push_back({closes(prev, b, cnt), b});
        if (exp_f[$][8]) cnt = 0;
        prev = b;
    endtask

    task automatic rx_idle(input int n);
        rx_valid_i <= 1'b0;
        repeat (n) @(posedge clock_i);
    endtask

    task automatic gap_close();
        exp_f[exp_f.size()-1][8] = 1'b1;
        cnt = 0;
    endtask

    task automatic frames_done();
        int k;
        for (k = 0; u_far.fq.size() < exp_f.size(); k++) begin
            if (k == 20000) hang("frame drain");
            @(negedge clock_i);
        end
        while (exp_f.size() > 0) begin
            check({7'h00, u_far.fq.pop_front()}, {7'h00, exp_f.pop_front()}, "frame byte");
        end
        check(16'(u_far.fq.size()), 16'h0000, "extra frame bytes");
        @(posedge clock_i);
    endtask

    task automatic net_send(input logic [7:0] b);
        int k;
        net_valid_i <= 1'b1;
        net_data_i <= b;
        @(negedge clock_i);
        for (k = 0; net_ready_o !== 1'b1; k++) begin
            if (k == 500) hang("network accept");
            @(negedge clock_i);
        end
        @(posedge clock_i);
        exp_t.push_back(b);
    endtask

    initial begin
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check(listen_port_o, 16'h0fa1, "default port");
        @(posedge clock_i);
        local_port_i <= 16'hffff;
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        check(listen_port_o, 16'hffff, "local port");
        @(posedge clock_i);
        repeat (8) send(filler());
        rx_idle(1);
        frames_done();
        // a second marker is only ever set beside a first one
        cfg(8'h0d, 8'h00, 16'h0000);
        repeat (5) send(filler());
        send(8'h0d);
        send(filler());
        send(8'h0d);
        rx_idle(1);
        frames_done();
        cfg(8'h0d, 8'h0a, 16'h0000);
        send(filler());
        send(8'h0d);
        send(filler());
        send(8'h0a);
        send(8'h0d);
        send(8'h0a);
        rx_idle(1);
        frames_done();
        repeat (1024) send(filler());
        rx_idle(1);
        frames_done();
        repeat (1022) send(filler());
        send(8'h0d);
        send(8'h0a);
        rx_idle(1);
        frames_done();
        send(filler());
        send(filler());
        rx_idle(300);
        @(negedge clock_i);
        check(16'(u_far.fq.size()), 16'h0000, "bytes held without gap limit");
        @(posedge clock_i);
        send(8'h0d);
        send(8'h0a);
        rx_idle(1);
        frames_done();
        // gap chosen well above the byte spacing so it has an effect
        cfg(8'h0d, 8'h0a, 16'h0005);
        repeat (4) begin
            send(filler());
            rx_idle(10);
        end
        rx_idle(60);
        gap_close();
        frames_done();
        cfg(8'h0d, 8'h0a, 16'h0001);
        repeat (6) begin
            send(filler());
            rx_idle(20);
            gap_close();
        end
        frames_done();
        repeat (20) net_send(8'($random(seed)));
        net_valid_i <= 1'b0;
        for (i = 0; u_far.tq.size() < 20; i++) begin
            if (i == 500) hang("serial transmit");
            @(negedge clock_i);
        end
        while (exp_t.size() > 0) begin
            check({8'h00, u_far.tq.pop_front()}, {8'h00, exp_t.pop_front()}, "tx byte");
        end
        @(posedge clock_i);
        open_req_i <= 4'b0011;
        port_ctrl_i <= 4'b0011;
        @(posedge clock_i);
        @(negedge clock_i);
        check({12'h000, conn_accept_o}, 16'h0001, "first accept");
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        check({15'h0000, listening_o}, 16'h0000, "no free slot");
        check({12'h000, conn_active_o}, 16'h0001, "single session");
        check({12'h000, port_ctrl_o}, 16'h0001, "owner control");
        check({15'h0000, local_params_o}, 16'h0000, "host params used");
        @(posedge clock_i);
        max_conn_i <= 3'h3;
        open_req_i <= 4'b1111;
        repeat (4) @(posedge clock_i);
        @(negedge clock_i);
        check({12'h000, conn_active_o}, 16'h0007, "three sessions");
        check({12'h000, port_ctrl_o}, 16'h0000, "control ignored");
        check({15'h0000, local_params_o}, 16'h0001, "local params");
        @(posedge clock_i);
        open_req_i <= 4'b0110;
        close_req_i <= 4'b0001;
        @(posedge clock_i);
        close_req_i <= 4'b0000;
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        check({15'h0000, suspend_o}, 16'h0001, "suspend on close");
        check({15'h0000, rx_ready_o}, 16'h0000, "serial held");
        check({15'h0000, net_ready_o}, 16'h0000, "network held");
        @(posedge clock_i);
        close_done_i <= 4'b0001;
        @(posedge clock_i);
        close_done_i <= 4'b0000;
        repeat (100) @(posedge clock_i);
        @(negedge clock_i);
        check({15'h0000, suspend_o}, 16'h0000, "resume after close");
        check({12'h000, conn_active_o}, 16'h0006, "sessions kept");
        @(posedge clock_i);
        idle_session_timeout_i <= 7'h02;
        @(negedge clock_i);
        for (i = 0; conn_drop_o === 4'h0; i++) begin
            if (i == 100) hang("session drop");
            @(negedge clock_i);
        end
        check({12'h000, conn_drop_o}, 16'h0006, "idle sessions dropped");
        repeat (2) @(posedge clock_i);
        @(negedge clock_i);
        check({15'h0000, listening_o}, 16'h0001, "listening again");
        stop_test();
    end
endmodule
